/* File: rtl/flash_status_pkg.sv */
/*
 holds the constants and types of the flash status word block.
 assumes a single 100 MHz clock domain and a serial host that drives
 chip select, serial clock and serial input from outside that domain.
*/
// How it works
// - byte2 bit7 is zero while busy
// - byte2 bits 6 and 4 read zero
// - byte2 bit5 set when erase/program failed
// - aborted operations leave fail flag clear
// - fail flag refreshed after every operation
// - byte2 bit3 shows lockdown still accepted
// - byte2 bit2 shows buffer two suspended
// - buffer two writes ignored while suspended
// - byte2 bit1 shows buffer one suspended
// - buffer one writes ignored while suspended
// - byte2 bit0 shows an erase suspended
// - compare flag holds latest compare result
// - byte1 carries fixed four-bit capacity code
// - protect flag shows sector protection enabled
// - page flag shows 512 or 528 pages
// - byte2 is read-only to the host
// - status opcode selects serial status output
// - bytes repeat while selected and clocked
// - byte1 bit6 holds compare result
package flash_status_pkg;

   ////////////////////////////////////////////////////////////////////
   // serial command and bit positions
   localparam logic [7:0] STATUS_READ_OP = 8'hD7;  // status read opcode
   localparam logic [2:0] BIT_LAST       = 3'h7;   // last bit of a byte
   localparam int         B1_READY       = 7;      // byte1 ready bit
   localparam int         B1_COMPARE     = 6;      // byte1 compare bit
   localparam int         B1_CODE_LO     = 2;      // byte1 code low bit
   localparam int         B1_PROTECT     = 1;      // byte1 protect bit
   localparam int         B1_PAGE        = 0;      // byte1 page size bit
   localparam int         B2_READY       = 7;      // byte2 ready bit
   localparam int         B2_FAIL        = 5;      // byte2 fail bit
   localparam int         B2_LOCKDOWN    = 3;      // byte2 lockdown bit
   localparam int         B2_SUSP2       = 2;      // byte2 buffer2 suspend
   localparam int         B2_SUSP1       = 1;      // byte2 buffer1 suspend
   localparam int         B2_ERASE       = 0;      // byte2 erase suspend

   ////////////////////////////////////////////////////////////////////
   // values after reset; the capacity code value is arbitrary
   localparam logic [3:0] CAPACITY_CODE  = 4'hA;   // arbitrary code
   localparam logic       RST_FAIL       = 1'h0;   // fail flag
   localparam logic       RST_LOCKDOWN   = 1'h1;   // lockdown allowed
   localparam logic       RST_SUSPEND    = 1'h0;   // suspend flags
   localparam logic       RST_COMPARE    = 1'h0;   // compare flag
   localparam logic [2:0] RST_BITCNT     = 3'h0;   // bit counter

   ////////////////////////////////////////////////////////////////////
   // serial engine states, one-hot
   typedef enum logic [3:0] {
      ST_IDLE   = 4'h1,
      ST_OPCODE = 4'h2,
      ST_SEND   = 4'h4,
      ST_IGNORE = 4'h8
   } link_state_t;

   // flags that the block itself keeps
   typedef struct packed {
      logic compare_differ;            // latest compare mismatched
      logic erase_program_fail;        // last erase/program failed
      logic lockdown_allowed;          // lockdown command accepted
      logic buffer2_program_suspended; // buffer2 program suspended
      logic buffer1_program_suspended; // buffer1 program suspended
      logic erase_held;                // an erase is suspended
   } status_flags_t;

   // one-cycle events from the command engines
   typedef struct packed {
      logic compare_done;    // compare finished
      logic compare_differ;  // its result, valid with compare_done
      logic op_done;         // erase or program finished
      logic op_fail;         // its result, valid with op_done
      logic op_abort;        // erase or program aborted
      logic lockdown_freeze; // lockdown command disabled for good
      logic susp1_set;       // buffer1 program suspended
      logic susp1_clr;       // buffer1 program resumed
      logic susp2_set;       // buffer2 program suspended
      logic susp2_clr;       // buffer2 program resumed
      logic erase_set;       // erase suspended
      logic erase_clr;       // erase resumed
   } status_events_t;

endpackage

/* File: rtl/flash_status_register.sv */
/*
 status word of the serial flash: keeps the flags, builds both status
 bytes and shifts them out on the serial output after the status read
 opcode, and gates buffer writes while a buffer program is suspended.
 assumes command engines on CLK_I give one-cycle events and levels,
 and a mode 0/3 host whose pins are sampled by CLK_I.
*/
module flash_status_register
   import flash_status_pkg::*;
(
   // clock and reset
   input  wire logic                            CLK_I,
   input  wire logic                            RST_I,
   // serial pins
   input  wire logic                            CS_N_I,
   input  wire logic                            SCK_I,
   input  wire logic                            SI_I,
   output      logic                            SO_O,
   output      logic                            SO_OE_O,
   // engine levels
   input  wire logic                            BUSY_I,
   input  wire logic                            PROTECT_I,
   input  wire logic                            PAGE_512_I,
   // engine events
   input  wire flash_status_pkg::status_events_t EVENTS_I,
   // buffer write gating
   input  wire logic                            BUF1_WR_REQ_I,
   input  wire logic                            BUF2_WR_REQ_I,
   output      logic                            BUF1_WR_EN_O,
   output      logic                            BUF2_WR_EN_O,
   // parallel view of the status word
   output      logic [15:0]                     STATUS_O
);
   import flash_status_pkg::*;

   ////////////////////////////////////////////////////////////////////
   // pin synchronisers and edge detection
   logic [2:0]    sync1_q;     // first stage, read only by stage two
   logic [2:0]    sync2_q;     // second stage: cs_n, sck, si
   logic          sck_prev_q;  // previous synced clock
   wire           cs_act;      // chip selected
   wire           sck_rise;    // host clock rising edge
   wire           sck_fall;    // host clock falling edge
   wire           si_bit;      // synced serial input

   // two flops on every pin before use
   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         sync1_q    <= 3'h7;
         sync2_q    <= 3'h7;
         sck_prev_q <= 1'h1;
      end else begin
         sync1_q    <= {CS_N_I, SCK_I, SI_I};
         sync2_q    <= sync1_q;
         sck_prev_q <= sync2_q[1];
      end
   end

   assign cs_act   = ~sync2_q[2];
   assign sck_rise = sync2_q[1] & ~sck_prev_q;
   assign sck_fall = ~sync2_q[1] & sck_prev_q;
   assign si_bit   = sync2_q[0];

   ////////////////////////////////////////////////////////////////////
   // status flags
   status_flags_t flags_q;     // kept flags
   status_flags_t flags_d;     // next flags

   // next flag values; events only, never serial reads
   always_comb begin
      flags_d = flags_q;
      // compare result replaced on each finish
      if (EVENTS_I.compare_done) begin
         flags_d.compare_differ = EVENTS_I.compare_differ;
      end
      // every finish refreshes the fail flag
      if (EVENTS_I.op_done) begin
         flags_d.erase_program_fail = EVENTS_I.op_fail;
      end else if (EVENTS_I.op_abort) begin
         // an abort never reports failure
         flags_d.erase_program_fail = 1'h0;
      end
      // lockdown once disabled stays disabled
      if (EVENTS_I.lockdown_freeze) begin
         flags_d.lockdown_allowed = 1'h0;
      end
      // suspend set wins over resume in the same cycle
      if (EVENTS_I.susp1_set) begin
         flags_d.buffer1_program_suspended = 1'h1;
      end else if (EVENTS_I.susp1_clr) begin
         flags_d.buffer1_program_suspended = 1'h0;
      end
      // buffer two suspend
      if (EVENTS_I.susp2_set) begin
         flags_d.buffer2_program_suspended = 1'h1;
      end else if (EVENTS_I.susp2_clr) begin
         flags_d.buffer2_program_suspended = 1'h0;
      end
      // erase suspend
      if (EVENTS_I.erase_set) begin
         flags_d.erase_held = 1'h1;
      end else if (EVENTS_I.erase_clr) begin
         flags_d.erase_held = 1'h0;
      end
   end

   // flag register
   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         flags_q <= '{RST_COMPARE, RST_FAIL, RST_LOCKDOWN,
                      RST_SUSPEND, RST_SUSPEND, RST_SUSPEND};
      end else begin
         flags_q <= flags_d;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // status bytes, built from live state; no host write path
   logic [7:0]    byte1;       // first status byte
   logic [7:0]    byte2;       // second status byte

   // assemble both bytes
   always_comb begin
      byte1 = 8'h00;
      byte1[B1_READY]                   = ~BUSY_I;
      byte1[B1_COMPARE]                 = flags_q.compare_differ;
      byte1[B1_CODE_LO+3:B1_CODE_LO]    = CAPACITY_CODE;
      byte1[B1_PROTECT]                 = PROTECT_I;
      byte1[B1_PAGE]                    = PAGE_512_I;
      // reserved bits stay zero from the default
      byte2 = 8'h00;
      byte2[B2_READY]                   = ~BUSY_I;
      byte2[B2_FAIL]                    = flags_q.erase_program_fail;
      byte2[B2_LOCKDOWN]                = flags_q.lockdown_allowed;
      byte2[B2_SUSP2]                   = flags_q.buffer2_program_suspended;
      byte2[B2_SUSP1]                   = flags_q.buffer1_program_suspended;
      byte2[B2_ERASE]                   = flags_q.erase_held;
   end

   ////////////////////////////////////////////////////////////////////
   // serial engine
   link_state_t   state_q;     // engine state
   logic [2:0]    bit_q;       // bit within byte
   logic [6:0]    op_sr_q;     // opcode bits taken so far
   logic          byte_sel_q;  // 0 first byte, 1 second byte
   logic [7:0]    out_sr_q;    // remaining bits of current byte
   logic          so_q;        // serial output bit
   logic          oe_q;        // serial output enable
   wire           op_match;    // completed opcode is status read
   wire [7:0]     cur_byte;    // byte that starts now

   assign op_match = ({op_sr_q, si_bit} == STATUS_READ_OP);
   assign cur_byte = byte_sel_q ? byte2 : byte1;

   // state, counters and shifters
   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         state_q    <= ST_IDLE;
         bit_q      <= RST_BITCNT;
         op_sr_q    <= 7'h00;
         byte_sel_q <= 1'h0;
         out_sr_q   <= 8'h00;
         so_q       <= 1'h0;
         oe_q       <= 1'h0;
      end else if (!cs_act) begin
         // deselect ends any transfer and floats the output
         state_q    <= ST_IDLE;
         bit_q      <= RST_BITCNT;
         byte_sel_q <= 1'h0;
         oe_q       <= 1'h0;
      end else begin
         case (state_q)
            ST_IDLE: begin
               // selected: start taking the opcode
               state_q <= ST_OPCODE;
               bit_q   <= RST_BITCNT;
            end
            ST_OPCODE: begin
               // opcode sampled on rising edges
               if (sck_rise) begin
                  op_sr_q <= {op_sr_q[5:0], si_bit};
                  bit_q   <= bit_q + 3'h1;
                  if (bit_q == BIT_LAST) begin
                     state_q <= op_match ? ST_SEND : ST_IGNORE;
                  end
               end
            end
            ST_SEND: begin
               // bits change on falling edges, msb first
               if (sck_fall) begin
                  oe_q  <= 1'h1;
                  bit_q <= bit_q + 3'h1;
                  if (bit_q == RST_BITCNT) begin
                     // fresh snapshot of live status per byte
                     so_q     <= cur_byte[7];
                     out_sr_q <= {cur_byte[6:0], 1'h0};
                  end else begin
                     so_q     <= out_sr_q[7];
                     out_sr_q <= {out_sr_q[6:0], 1'h0};
                  end
                  // after each byte switch, wrapping back
                  if (bit_q == BIT_LAST) begin
                     byte_sel_q <= ~byte_sel_q;
                  end
               end
            end
            ST_IGNORE: begin
               // other opcodes: stay quiet until deselect
               oe_q <= 1'h0;
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   assign SO_O    = so_q;
   assign SO_OE_O = oe_q;

   ////////////////////////////////////////////////////////////////////
   // buffer write gating and parallel status
   logic          buf1_en_q;   // buffer1 write allowed
   logic          buf2_en_q;   // buffer2 write allowed
   logic [15:0]   status_q;    // registered status word

   // suspended buffers refuse modification
   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         buf1_en_q <= 1'h0;
         buf2_en_q <= 1'h0;
         status_q  <= 16'h0000;
      end else begin
         buf1_en_q <= BUF1_WR_REQ_I & ~flags_q.buffer1_program_suspended;
         buf2_en_q <= BUF2_WR_REQ_I & ~flags_q.buffer2_program_suspended;
         status_q  <= {byte1, byte2};
      end
   end

   assign BUF1_WR_EN_O = buf1_en_q;
   assign BUF2_WR_EN_O = buf2_en_q;
   assign STATUS_O     = status_q;

endmodule

/* File: tb/flash_status_register_checker.sv */
/*
 concurrent checks on the status word block, bound to its top module.
 assumes one clock domain and a status word one cycle behind live state.
*/
module flash_status_register_checker
   import flash_status_pkg::*;
(
   // clock, reset, levels and events
   input wire logic                             CLK_I,
   input wire logic                             RST_I,
   input wire logic                             CS_N_I,
   input wire logic                             BUSY_I,
   input wire logic                             PROTECT_I,
   input wire logic                             PAGE_512_I,
   input wire flash_status_pkg::status_events_t EVENTS_I,
   input wire logic                             BUF1_WR_REQ_I,
   input wire logic                             BUF2_WR_REQ_I,
   // observed outputs
   input wire logic                             SO_OE_O,
   input wire logic                             BUF1_WR_EN_O,
   input wire logic                             BUF2_WR_EN_O,
   input wire logic [15:0]                      STATUS_O
);
   default clocking @(posedge CLK_I); endclocking
   default disable iff (RST_I);
   ////////////////////////////////////////////////////////////////////
   // counts edges since reset so the live word has settled
   logic [1:0] up_q;
   always_ff @(posedge CLK_I) begin
      if (RST_I) up_q <= 2'h0;
      else if (up_q != 2'h3) up_q <= up_q + 2'h1;
   end
   wire up = (up_q == 2'h3);
   ////////////////////////////////////////////////////////////////////
   property p_ready; up |-> STATUS_O[15] == !$past(BUSY_I) && STATUS_O[7] == !$past(BUSY_I);
   endproperty
   a_ready: assert property (p_ready) else $error("ready bits wrong");
   property p_resv; STATUS_O[6] == 1'b0 && STATUS_O[4] == 1'b0; endproperty
   a_resv: assert property (p_resv) else $error("reserved bits set");
   property p_code; up |-> STATUS_O[13:10] == CAPACITY_CODE; endproperty
   a_code: assert property (p_code) else $error("capacity code wrong");
   property p_pins; up |-> STATUS_O[9:8] == $past({PROTECT_I, PAGE_512_I}); endproperty
   a_pins: assert property (p_pins) else $error("protect or page bit wrong");
   property p_fail;
      EVENTS_I.op_done ##1 !(EVENTS_I.op_done || EVENTS_I.op_abort)
      |=> STATUS_O[5] == $past(EVENTS_I.op_fail, 2);
   endproperty
   a_fail: assert property (p_fail) else $error("fail flag not refreshed");
   property p_abort;
      EVENTS_I.op_abort && !EVENTS_I.op_done ##1 !EVENTS_I.op_done |=> !STATUS_O[5];
   endproperty
   a_abort: assert property (p_abort) else $error("fail flag set by abort");
   property p_cmp;
      EVENTS_I.compare_done ##1 !EVENTS_I.compare_done
      |=> STATUS_O[14] == $past(EVENTS_I.compare_differ, 2);
   endproperty
   a_cmp: assert property (p_cmp) else $error("compare flag wrong");
   property p_lock; up && !STATUS_O[3] |=> !STATUS_O[3]; endproperty
   a_lock: assert property (p_lock) else $error("lockdown flag came back");
   property p_erase; EVENTS_I.erase_set ##1 !EVENTS_I.erase_clr |=> STATUS_O[0]; endproperty
   a_erase: assert property (p_erase) else $error("erase flag not set");
   property p_gate;
      up |-> {BUF2_WR_EN_O, BUF1_WR_EN_O} ==
             ($past({BUF2_WR_REQ_I, BUF1_WR_REQ_I}) & ~STATUS_O[2:1]);
   endproperty
   a_gate: assert property (p_gate) else $error("buffer write not gated");
   property p_oe; CS_N_I [*6] |-> !SO_OE_O; endproperty
   a_oe: assert property (p_oe) else $error("output driven while deselected");
endmodule
bind flash_status_register flash_status_register_checker chk_u (.CLK_I, .RST_I, .CS_N_I,
   .BUSY_I, .PROTECT_I, .PAGE_512_I, .EVENTS_I, .BUF1_WR_REQ_I, .BUF2_WR_REQ_I, .SO_OE_O,
   .BUF1_WR_EN_O, .BUF2_WR_EN_O, .STATUS_O);

/* File: tb/spi_host_model.sv */
/*
 serial host that polls the status word, mode 0, 160 ns link clock.
 assumes the caller starts a frame only after reset has settled.
*/
module spi_host_model (
   output logic      cs_n,
   output logic      sck,
   output logic      si,
   input  wire logic so,
   input  wire logic so_oe
);
   timeunit 1ns;
   timeprecision 1ns;
   // link clock stands still low between frames
   initial begin
      cs_n = 1'b1;
      sck = 1'b0;
      si = 1'b0;
   end
   // select, shift the opcode msb first, then clock n bits back
   task automatic read(input logic [7:0] op, input int n, output logic [31:0] d,
                       output int k);
      d = '0;
      k = 0;
      cs_n = 1'b0;
      for (int i = 7; i >= 0; i--) begin
         si = op[i];
         #80 sck = 1'b1;
         #80 sck = 1'b0;
      end
      // keep clocking fresh bytes; the released input toggles each bit
      for (int i = 0; i < n; i++) begin
         si = ~si;
         #80 sck = 1'b1;
         d = {d[30:0], so};
         k += int'(so_oe);
         #80 sck = 1'b0;
      end
      #80 cs_n = 1'b1;
      si = ~si;
      #200;
   endtask
endmodule

/* File: tb/tb.sv */
/*
 self-checking bench of the status word block.
 assumes the host model in spi_host_model and the package constants.
*/
module tb;
   import flash_status_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0, rst = 1'b1, busy = 1'b0, prot = 1'b1, pg = 1'b0;
   logic cs_n, sck, si, so, so_oe;
   logic [1:0] req = 2'h0, en;
   logic [15:0] st;
   status_events_t ev = '0;
   // expected flags
   logic f_cmp = 1'b0, f_fail = 1'b0, f_lock = 1'b1, f_s2 = 1'b0, f_s1 = 1'b0, f_es = 1'b0;
   int mismatches = 0, tests_run = 0;
   always #5 clk = ~clk;
   flash_status_register dut_u (.CLK_I(clk), .RST_I(rst), .CS_N_I(cs_n), .SCK_I(sck),
      .SI_I(si), .SO_O(so), .SO_OE_O(so_oe), .BUSY_I(busy), .PROTECT_I(prot),
      .PAGE_512_I(pg), .EVENTS_I(ev), .BUF1_WR_REQ_I(req[0]), .BUF2_WR_REQ_I(req[1]),
      .BUF1_WR_EN_O(en[0]), .BUF2_WR_EN_O(en[1]), .STATUS_O(st));
   spi_host_model host_u (.cs_n(cs_n), .sck(sck), .si(si), .so(so), .so_oe(so_oe));
   ////////////////////////////////////////////////////////////////////
   function automatic logic [15:0] wexp();
      return {~busy, f_cmp, CAPACITY_CODE, prot, pg, ~busy, 1'b0, f_fail, 1'b0, f_lock,
              f_s2, f_s1, f_es};
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED %0t %s", $time, m);
      end
   endtask
   task automatic conclude();
      if (mismatches == 0 && tests_run > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////
   // busy drops mid-frame: later bytes must show ready
   task automatic t_poll();
      logic [31:0] d;
      logic [15:0] w1;
      int k;
      busy = 1'b1;
      @(posedge clk);
      #1 w1 = wexp();
      fork
         host_u.read(8'hD7, 32, d, k);
         begin
            #3200 busy = 1'b0;
         end
      join
      chk(d, {w1, wexp()}, "serial word");
      chk(k, 32, "output enable");
      chk(st, wexp(), "read side effect");
   endtask
   // another opcode must leave the output undriven
   task automatic t_refused();
      logic [31:0] d;
      int k;
      host_u.read(8'h9F, 16, d, k);
      chk(k, 0, "refused opcode");
   endtask
   // each event pulse, then word and write gating
   task automatic t_events();
      // 12'h030 raises suspend and resume together: the set must win
      logic [11:0] tab [14] = '{12'h300, 12'h200, 12'h300, 12'h080, 12'hC00, 12'h800,
         12'h020, 12'h030, 12'h008, 12'h002, 12'h010, 12'h004, 12'h001, 12'h040};
      status_events_t e;
      logic [15:0] w;
      req = 2'h3;
      for (int i = 0; i < 14; i++) begin
         e = status_events_t'(tab[i]);
         @(posedge clk);
         #1 ev = e;
         if (e.op_done) f_fail = e.op_fail;
         else if (e.op_abort) f_fail = 1'b0;
         if (e.compare_done) f_cmp = e.compare_differ;
         if (e.lockdown_freeze) f_lock = 1'b0;
         f_s1 = e.susp1_set | (f_s1 & ~e.susp1_clr);
         f_s2 = e.susp2_set | (f_s2 & ~e.susp2_clr);
         f_es = e.erase_set | (f_es & ~e.erase_clr);
         @(posedge clk);
         #1 ev = '0;
         if (i == 6) {prot, pg} = 2'h1;
         repeat (3) @(posedge clk);
         #1 w = wexp();
         chk(st[15:8], w[15:8], "byte one");
         chk(st[7:0], w[7:0], "byte two");
         chk(en, 2'(~{f_s2, f_s1}), "write gate");
         if (i == 8) t_poll();
      end
   endtask
   ////////////////////////////////////////////////////////////////////
   initial begin
      repeat (2) @(posedge clk);
      #1 rst = 1'b0;
      repeat (4) @(posedge clk);
      #1;
      chk(st, wexp(), "reset word");
      chk(en, 2'h0, "idle write gate");
      t_refused();
      t_events();
      t_poll();
      conclude();
   end
   // cuts a hang short
   initial begin
      #500000;
      mismatches++;
      conclude();
   end
endmodule
